// ---- hw/hib_ctrl.sv ----
// hibernation control: battery check, clock setup, retained memory, interrupts
//
// Functional notes
// - forced check starts measurement immediately
// - busy reads nonzero until result valid
// - low result sets low battery flag
// - unmasked low battery raises interrupt
// - hibernation request waits while check busy
// - oscillator power down, strong or weak drive
// - timebase raw or crystal divided by 128
// - sixty-four retained 32-bit words
// - memory read returns last written word
// - disabled unit runs no check, event capture, hibernation, timebase or memory write
// - flags stay set until written one
// - mask bit zero blocks that source
// - status, mask, clear share four-bit layout
// - raw and masked status both readable
`timescale 1ns/1ps
`include "hib_ctrl_defines.svh"
module hib_ctrl #(
  parameter int mem_words = 64,
  parameter int meas_cycles = `HIB_MEAS_CYC,
  parameter int period_cycles = `HIB_PERIOD_CYC,
  parameter int div_ratio = `HIB_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_raw,
  input wire logic xtal_in,
  input wire logic bat_low,
  input wire hib_ctrl_pkg::hib_evt_t events,
  output hib_ctrl_pkg::hib_ctrl_t ctrl,
  output logic timebase,
  output logic irq
);
  import hib_ctrl_pkg::*;

  localparam int mw = $clog2(mem_words);
  localparam int cw = $clog2(period_cycles + 1);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic setup; // setup cycle of any transfer
  logic wr_en; // write takes effect this edge
  logic rd_en; // read data captured this edge
  logic mem_hit; // address inside retained memory
  logic known; // address maps to something
  // unmapped addresses answer with pslverr; writes refused while disabled drop silently
  assign setup = psel & ~penable;
  assign mem_hit = (paddr >= `HIB_MEM_BASE) && (paddr <= `HIB_MEM_TOP) && (paddr[1:0] == 2'h0);
  assign wr_en = clk_en & psel & penable & pready & pwrite;
  assign rd_en = clk_en & setup & ~pwrite;

  // map check, all registers and memory words
  always_comb
  begin
    case (paddr)
      `HIB_CTL_OFF, `HIB_CLK_OFF, `HIB_CHECK_OFF, `HIB_REQ_OFF, `HIB_RIS_OFF,
      `HIB_MASK_OFF, `HIB_MIS_OFF, `HIB_CLEAR_OFF, `HIB_STATE_OFF, `HIB_EVENT_OFF:
        known = 1'b1;
      default:
        known = mem_hit;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // software state

  logic enable; // unit enable
  logic abort_low; // abort hibernation on low battery
  logic [1:0] osc_mode; // oscillator drive choice
  logic clk_sel; // divided crystal timebase
  logic [3:0] mask; // interrupt enables
  logic [3:0] raw; // sticky interrupt flags
  logic [3:0] evt_set; // events this cycle
  logic chk_req; // forced check written
  logic hib_req; // hibernation requested
  logic hib_pending; // request parked
  logic [31:0] mem [mem_words]; // retained words, no reset so contents persist
  logic [31:0] wmask; // byte lanes from strobes

  // expand byte strobes to bit mask
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = {8{pstrb[i]}};
  end

  assign chk_req = wr_en & (paddr == `HIB_CHECK_OFF) & pwdata[0];
  assign hib_req = wr_en & (paddr == `HIB_REQ_OFF) & pwdata[0];

  // enable and configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // unit comes out of reset disabled; software must enable it first
      enable <= 1'(`HIB_CTL_RST >> `HIB_CTL_EN_BIT);
      abort_low <= 1'(`HIB_CTL_RST >> `HIB_CTL_ABORT_BIT);
      osc_mode <= 2'h0;
      clk_sel <= 1'b0;
      mask <= `HIB_MASK_RST;
    end
    else if (wr_en)
    begin
      if (paddr == `HIB_CTL_OFF)
      begin
        enable <= pwdata[`HIB_CTL_EN_BIT];
        abort_low <= pwdata[`HIB_CTL_ABORT_BIT];
      end
      // an unlisted drive code is dropped so the field only holds legal choices
      if (paddr == `HIB_CLK_OFF && enable)
      begin
        if (pwdata[`HIB_CLK_OSC_LSB +: 2] != 2'h3)
          osc_mode <= pwdata[`HIB_CLK_OSC_LSB +: 2];
        clk_sel <= pwdata[`HIB_CLK_SEL_BIT];
      end
      // a zero bit blocks only its own source
      if (paddr == `HIB_MASK_OFF)
        mask <= pwdata[3:0];
    end
  end

  // retained memory writes, byte lanes honoured
  always_ff @(posedge pclk)
  begin
    if (wr_en && mem_hit && enable)
      mem[paddr[mw+1:2]] <= (mem[paddr[mw+1:2]] & ~wmask) | (pwdata & wmask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // battery measurement sequencer

  typedef enum logic [1:0] {idle_s, measure_s} meas_state_t;
  meas_state_t state; // sequencer state
  logic [cw-1:0] period_cnt; // idle cycles since last check, periodic or forced
  logic [cw-1:0] meas_cnt; // cycles left in measurement
  logic busy; // measurement in progress
  logic low_done; // completed check found low battery
  assign busy = (state == measure_s);

  // periodic interval counter and measurement timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= idle_s;
      period_cnt <= '0;
      meas_cnt <= '0;
      low_done <= 1'b0;
    end
    else if (clk_en)
    begin
      low_done <= 1'b0;
      if (!enable)
      begin
        state <= idle_s;
        period_cnt <= '0;
      end
      else
      begin
        case (state)
          idle_s:
          begin
            // forced request skips the rest of the interval
            if (chk_req || period_cnt == cw'(period_cycles - 1))
            begin
              state <= measure_s;
              meas_cnt <= cw'(meas_cycles - 1);
              period_cnt <= '0;
            end
            else
              period_cnt <= period_cnt + 1'b1;
          end
          measure_s:
          begin
            if (meas_cnt == '0)
            begin
              state <= idle_s;
              low_done <= bat_low;
            end
            else
              meas_cnt <= meas_cnt - 1'b1;
          end
          default:
            state <= idle_s;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags

  assign evt_set = enable ? {events.match1, events.match0, low_done, events.pin_wake} : 4'h0;

  // sticky flags, set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw <= 4'h0;
    else if (clk_en)
    begin
      if (wr_en && paddr == `HIB_CLEAR_OFF)
        raw <= (raw & ~pwdata[3:0]) | evt_set;
      else
        raw <= raw | evt_set;
    end
  end

  // interrupt line, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(raw & mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // hibernation request handling

  // request parks while a check runs; low battery may abort it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hib_pending <= 1'b0;
      ctrl <= '0;
    end
    else if (clk_en)
    begin
      ctrl.osc_mode <= osc_mode;
      ctrl.clock_source_divided <= clk_sel;
      ctrl.meas_start <= enable && state == idle_s && (chk_req || period_cnt == cw'(period_cycles - 1));
      if (!enable)
        hib_pending <= 1'b0;
      else if (hib_req || hib_pending)
      begin
        if (busy || low_done)
          hib_pending <= 1'b1;
        else
        begin
          hib_pending <= 1'b0;
          if (!(abort_low && raw[`HIB_INT_LOW_BAT]))
            ctrl.regulator_off <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebase: raw oscillator or crystal divided

  localparam int hw = $clog2(div_ratio / 2); // half-period counter width, div_ratio must be at least 4
  logic [hw-1:0] div_cnt; // crystal edges seen in this half period
  logic xtal_q; // previous crystal level
  logic div_out; // divided clock level

  // count crystal edges sampled on pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= '0;
      xtal_q <= 1'b0;
      div_out <= 1'b0;
      timebase <= 1'b0;
    end
    else if (clk_en)
    begin
      xtal_q <= xtal_in;
      // inputs treated as synchronous; crystal must be well under pclk/2
      if (enable && xtal_in && !xtal_q)
      begin
        // toggle every half ratio so one output period spans div_ratio crystal cycles
        if (div_cnt == hw'(div_ratio / 2 - 1))
        begin
          div_cnt <= '0;
          div_out <= ~div_out;
        end
        else
          div_cnt <= div_cnt + 1'b1;
      end
      if (!enable || osc_mode == oscillator_power_down && !clk_sel)
        timebase <= 1'b0;
      else
        timebase <= clk_sel ? div_out : osc_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: read in setup, ready in access

  // zero-wait slave: data and ready both come from flops
  // read data is captured at setup so the first access cycle can already answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= setup;
      pslverr <= setup & ~known;
      if (rd_en)
      begin
        if (mem_hit)
          prdata <= mem[paddr[mw+1:2]];
        else
        begin
          case (paddr)
            `HIB_CTL_OFF: prdata <= {30'h0, abort_low, enable};
            `HIB_CLK_OFF: prdata <= {27'h0, clk_sel, 2'h0, osc_mode};
            `HIB_CHECK_OFF: prdata <= {31'h0, busy};
            `HIB_RIS_OFF: prdata <= {28'h0, raw};
            `HIB_MASK_OFF: prdata <= {28'h0, mask};
            `HIB_MIS_OFF: prdata <= {28'h0, raw & mask};
            `HIB_STATE_OFF: prdata <= {29'h0, ctrl.regulator_off, hib_pending, busy};
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule : hib_ctrl

// ---- hw/hib_ctrl_defines.svh ----
// register offsets, field positions, reset values and timing counts of the hibernation control block
`ifndef HIB_CTRL_DEFINES_SVH
`define HIB_CTRL_DEFINES_SVH
// register byte offsets
`define HIB_CTL_OFF 12'h000
`define HIB_CLK_OFF 12'h004
`define HIB_CHECK_OFF 12'h008
`define HIB_REQ_OFF 12'h00c
`define HIB_RIS_OFF 12'h010
`define HIB_MASK_OFF 12'h014
`define HIB_MIS_OFF 12'h018
`define HIB_CLEAR_OFF 12'h01c
`define HIB_STATE_OFF 12'h020
`define HIB_EVENT_OFF 12'h024
`define HIB_MEM_BASE 12'h100
`define HIB_MEM_TOP 12'h1fc
// control register fields
`define HIB_CTL_EN_BIT 0
`define HIB_CTL_ABORT_BIT 1
// clock register fields
`define HIB_CLK_OSC_LSB 0
`define HIB_CLK_SEL_BIT 4
// interrupt bit layout
`define HIB_INT_PIN_WAKE 0
`define HIB_INT_LOW_BAT 1
`define HIB_INT_MATCH0 2
`define HIB_INT_MATCH1 3
// reset values
`define HIB_CTL_RST 32'h0000_0000
`define HIB_MASK_RST 4'h0
// timing: battery measurement time in ns and periodic interval in us
`define HIB_MEAS_NS 2000
`define HIB_PERIOD_US 1000
`define HIB_CLK_NS 100
`define HIB_MEAS_CYC ((`HIB_MEAS_NS + `HIB_CLK_NS - 1) / `HIB_CLK_NS)
`define HIB_PERIOD_CYC ((`HIB_PERIOD_US * 1000) / `HIB_CLK_NS)
`define HIB_DIV 128
`endif

// ---- hw/hib_ctrl_pkg.sv ----
// types shared by the hibernation control block
package hib_ctrl_pkg;
  // oscillator drive choices
  typedef enum logic [1:0] {
    oscillator_power_down = 2'h0,
    oscillator_strong_drive = 2'h1,
    oscillator_weak_drive = 2'h2
  } osc_mode_t;
  // analog and clock side controls leaving the block
  typedef struct packed {
    logic [1:0] osc_mode;
    logic clock_source_divided;
    logic meas_start;
    logic regulator_off;
  } hib_ctrl_t;
  // events arriving from the rtc and wake logic
  typedef struct packed {
    logic pin_wake;
    logic match0;
    logic match1;
  } hib_evt_t;
endpackage : hib_ctrl_pkg

// ---- test/hib_ctrl_asserts.sv ----
// checker: bus, interrupt and control assertions for hib_ctrl
`timescale 1ns/1ps
module hib_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire hib_ctrl_pkg::hib_ctrl_t ctrl,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup; // setup phase seen by the slave
  logic wacc; // completed write
  assign setup = psel & ~penable & clk_en;
  assign wacc = psel & penable & pwrite & pready;
  ////////////////////////////////////////////////////////////////
  AST_READY_NEXT: assert property (setup |=> pready) else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_UNMAPPED: assert property (setup && !pwrite && paddr == 12'h030 |=> pslverr && prdata == 32'h0)
    else $error("unmapped read accepted");
  AST_MAPPED: assert property (setup && paddr == 12'h000 |=> !pslverr) else $error("mapped read refused");
  AST_MEAS_PULSE: assert property (ctrl.meas_start |=> !ctrl.meas_start) else $error("start held");
  AST_REG_OFF: assert property (ctrl.regulator_off |=> ctrl.regulator_off) else $error("off dropped");
  AST_MASK_ZERO: assert property (wacc && paddr == 12'h014 && pwdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("irq with empty mask");
  AST_IRQ_HOLD: assert property (irq && !wacc && !$past(wacc) |=> irq) else $error("irq dropped");
  AST_IRQ_FALL: assert property ($fell(irq) && $past(presetn) |-> $past(wacc, 2))
    else $error("irq fell without write");
  // main scenarios
  cover property (ctrl.meas_start);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule : hib_ctrl_asserts
bind hib_ctrl hib_ctrl_asserts chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ctrl(ctrl), .irq(irq));

// ---- test/hib_ctrl_bench.sv ----
// self-checking bench for hib_ctrl
`timescale 1ns/1ps
module hib_ctrl_bench;
  import hib_ctrl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic bat_low = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] d;
  logic [31:0] mv [64]; // expected memory words
  logic [3:0] b;
  logic [7:0] cnt = 8'h00; // slow clocks for osc and crystal
  logic pready, pslverr, irq, timebase;
  hib_evt_t events = '0;
  hib_ctrl_t ctrl;
  logic [33:0] exp_q [$]; // {irq, error, data} per read
  int err_total = 0;
  int total_checks = 0;
  int seed = 85895;
  int i, n;
  always #50 pclk = ~pclk;
  always @(posedge pclk) cnt <= cnt + 8'h01;
  // long period keeps periodic checks out of the way of the whole run
  hib_ctrl #(.meas_cycles(12), .period_cycles(5000)) uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_raw(cnt[7]), .xtal_in(cnt[1]),
    .bat_low(bat_low), .events(events), .ctrl(ctrl), .timebase(timebase), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic cmp(input string s, input logic [33:0] x, input logic [33:0] y);
    total_checks++;
    if (x !== y)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, x, y);
    end
  endtask : cmp
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  // one apb transfer; reads note their expected answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic ei);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    if (!w)
      exp_q.push_back({ei, a == 12'h030, dd});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 16);
    if (!pready)
    begin
      err_total++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // watcher: compares each read answer with the oldest note
  always @(posedge pclk)
    if (pready && !pwrite)
      cmp("read", exp_q.pop_front(), {irq, pslverr, prdata});
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 32'h0, 0);
    apb(0, 12'h014, 32'h0, 0);
    apb(0, 12'h030, 32'h0, 0);
    apb(1, 12'h008, 32'h1, 0);
    apb(0, 12'h008, 32'h0, 0);
    apb(1, 12'h000, 32'h1, 0);
    fin("reset");
    for (i = 0; i < 64; i += 21)
    begin
      mv[i] = $random(seed);
      apb(1, 12'h100 + 12'(4 * i), mv[i], 0);
    end
    for (i = 0; i < 64; i += 21)
      apb(0, 12'h100 + 12'(4 * i), mv[i], 0);
    apb(1, 12'h000, 32'h0, 0);
    apb(1, 12'h100, ~mv[0], 0);
    apb(0, 12'h100, mv[0], 0);
    apb(1, 12'h000, 32'h1, 0);
    fin("memory");
    for (i = 0; i < 3; i++)
    begin
      d = {27'h0, i[0], 2'h0, i[1:0]};
      apb(1, 12'h004, d, 0);
      apb(0, 12'h004, d, 0);
      cmp("clock", 34'({ctrl.osc_mode, ctrl.clock_source_divided}), 34'({i[1:0], i[0]}));
      if (i == 0)
        cmp("timebase", 34'(timebase), 34'h0);
    end
    apb(1, 12'h004, 32'h3, 0);
    apb(0, 12'h004, d, 0);
    // divided crystal: cnt[1] gives one crystal period every 4 clocks
    apb(1, 12'h004, 32'h11, 0);
    repeat (2) @(posedge pclk);
    for (n = 0; n < 600 && timebase; n++)
      @(posedge pclk);
    for (n = 0; n < 600 && !timebase; n++)
      @(posedge pclk);
    for (n = 0; n < 600 && timebase; n++)
      @(posedge pclk);
    for (i = 0; i < 600 && !timebase; i++)
      @(posedge pclk);
    cmp("timebase", 34'(n + i), 34'(128 * 4));
    fin("clock");
    for (i = 0; i < 3; i++)
    begin
      events <= 3'b100 >> i;
      @(posedge pclk);
      events <= '0;
      b = 4'h1 << (i + (i > 0));
      apb(1, 12'h014, 32'h0, 0);
      apb(0, 12'h010, {28'h0, b}, 0);
      apb(0, 12'h018, 32'h0, 0);
      apb(1, 12'h014, {28'h0, b}, 0);
      apb(0, 12'h018, {28'h0, b}, 1);
      apb(1, 12'h01c, {28'h0, b}, 0);
      apb(0, 12'h010, 32'h0, 0);
    end
    fin("interrupts");
    apb(1, 12'h014, 32'h2, 0);
    bat_low <= 1'b1;
    apb(1, 12'h008, 32'h1, 0);
    apb(1, 12'h00c, 32'h1, 0);
    apb(0, 12'h020, 32'h3, 0);
    cmp("regulator", 34'(ctrl.regulator_off), 34'h0);
    repeat (20) @(posedge pclk);
    apb(0, 12'h008, 32'h0, 1);
    apb(0, 12'h010, 32'h2, 1);
    cmp("regulator", 34'(ctrl.regulator_off), 34'h1);
    apb(1, 12'h01c, 32'h2, 0);
    apb(0, 12'h018, 32'h0, 0);
    fin("battery");
    // mid-run reset: retained words survive, abort drops a low-battery request
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h100, mv[0], 0);
    apb(1, 12'h000, 32'h3, 0);
    apb(1, 12'h008, 32'h1, 0);
    apb(1, 12'h00c, 32'h1, 0);
    repeat (20) @(posedge pclk);
    apb(0, 12'h020, 32'h0, 0);
    apb(0, 12'h010, 32'h2, 0);
    cmp("regulator", 34'(ctrl.regulator_off), 34'h0);
    fin("abort");
    conclude();
  end
endmodule : hib_ctrl_bench
